// *** logic/eag_top.sv ***
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Register direct is byte wide except word move/alu, small step, mul, div.
// - Register indirect uses the whole 16-bit register as the address.
// - Displacement mode, moves only, adds bytes 3-4 to the register.
// - Post-increment accesses at the register, then adds 1 or 2.
// - Pre-decrement subtracts 1 or 2 first, then accesses the new value.
// - Short absolute byte moves force the upper address byte to ones.
// - 16-bit absolute only for byte move, word move, jump and call.
// - Immediate is byte 2 (8 bits) or bytes 3-4; 16-bit for word moves.
// - Small-step add/subtract carry an implied immediate of 1 or 2.
// - Immediate bit index is three bits from byte 2 or byte 4.
// - Branches add sign-extended byte 2 to the program counter.
// - Memory indirect reads the target word from page zero.
// - Odd word or branch addresses lose bit 0, no error raised.
// - Byte arithmetic and logic take register direct or immediate only.
// - Data transfers skip relative and memory indirect; byte moves skip 16-bit immediate, word moves short absolute and 8-bit immediate.
// - Bit ops address by register, indirect or short absolute.
// - Push is word pre-decrement, pop word post-increment, via stack.
// - The two synchronised byte-transfer instructions are refused.
// - Register seven is the stack pointer for stack modes.
// - The program counter bit 0 is always taken as zero.
module eag_top import eag_pkg::*; (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic REQ_VALID,
   input wire eag_class_e REQ_CLASS,
   input wire eag_mode_e REQ_MODE,
   input wire logic REQ_STORE,
   input wire logic REQ_STEP2,
   input wire logic REQ_BIT_BYTE4,
   input wire logic [3:0] REQ_REG,
   input wire logic [3:0] REQ_BITREG,
   input wire logic [7:0] REQ_BYTE2,
   input wire logic [15:0] REQ_BYTE34,
   input wire logic [127:0] REG_FILE,
   input wire logic [15:0] PROGRAM_COUNTER,
   input wire logic [15:0] MEM_RD_DATA,
   input wire logic MEM_RD_VALID,
   output logic BUSY,
   output logic EA_DONE,
   output logic EA_ILLEGAL,
   output logic EA_MEM,
   output logic IS_BRANCH,
   output logic [15:0] EA_ADDR,
   output logic ACC_WORD,
   output logic [15:0] OPERAND_VALUE,
   output logic IMM_VALID,
   output logic [15:0] IMM_VALUE,
   output logic [2:0] BIT_INDEX,
   output logic WB_EN,
   output logic [2:0] WB_REG,
   output logic [15:0] WB_DATA,
   output logic MEM_RD_REQ,
   output logic [15:0] MEM_RD_ADDR
);

   eag_state_e st_q;
   logic acc, legal_c, word_c, jump_c, al_c;
   logic mem_c, immv_c, wb_c, br_c, rdreq_c;
   logic [2:0] sel_c, bit_c;
   logic [7:0] bv_c;
   logic [15:0] rv_c, step_c, base_c, off_c, sum_c, sum_al_c;
   logic [15:0] ea_c, imm_c, opv_c;

   function automatic logic [15:0] reg_pick(input logic [127:0] f,
                                            input logic [2:0] s);
      return f[{s, 4'h0} +: 16];
   endfunction

   // Byte registers: field bit 3 picks the low half
   function automatic logic [7:0] byte_pick(input logic [127:0] f,
                                            input logic [3:0] s);
      logic [15:0] w;
      w = reg_pick(f, s[2:0]);
      return s[3] ? w[7:0] : w[15:8];
   endfunction

   function automatic logic [15:0] even_addr(input logic [15:0] a,
                                             input logic w);
      return w ? {a[15:1], 1'b0} : a;
   endfunction

   function automatic logic is_word(input eag_class_e c,
                                    input eag_mode_e m);
      logic wd;
      wd = c == CL_WORD_MOVE || c == CL_PUSH || c == CL_POP;
      if (m == M_REG && (c == CL_WORD_ALU || c == CL_SMALL_STEP ||
                         c == CL_MULDIV)) begin
         wd = 1'b1;
      end
      return wd;
   endfunction

   function automatic logic mode_ok(input eag_class_e c,
                                    input eag_mode_e m,
                                    input logic st);
      logic ok, mv;
      ok = 1'b0;
      // Loads walk up, stores walk down
      mv = m != M_PCREL && m != M_MEMIND &&
           !(m == M_POSTINC && st) && !(m == M_PREDEC && !st);
      case (c)
         CL_BYTE_MOVE: ok = mv && m != M_IMM16;
         CL_WORD_MOVE: ok = mv && m != M_ABS8 && m != M_IMM8;
         CL_WORD_ALU, CL_SMALL_STEP, CL_MULDIV, CL_OTHER: ok = m == M_REG;
         CL_BYTE_ALU: ok = m == M_REG || m == M_IMM8;
         CL_BIT_REGNUM, CL_BIT_IMM: begin
            ok = m == M_REG || m == M_IND || m == M_ABS8;
         end
         CL_BRANCH: ok = m == M_PCREL;
         CL_JUMP: ok = m == M_IND || m == M_ABS16 || m == M_MEMIND;
         CL_PUSH: ok = m == M_PREDEC;
         CL_POP: ok = m == M_POSTINC;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   assign acc = st_q == ST_IDLE && REQ_VALID;

   always_comb begin
      jump_c = REQ_CLASS == CL_JUMP;
      // Stack classes always go through register seven
      sel_c = (REQ_CLASS == CL_PUSH || REQ_CLASS == CL_POP) ?
              STACK_REG : REQ_REG[2:0];
      rv_c = reg_pick(REG_FILE, sel_c);
      word_c = is_word(REQ_CLASS, REQ_MODE);
      step_c = word_c ? STEP_WORD : STEP_BYTE;
      legal_c = mode_ok(REQ_CLASS, REQ_MODE, REQ_STORE);
      base_c = rv_c;
      off_c = 16'h0000;
      al_c = word_c;
      case (REQ_MODE)
         M_DISP: off_c = REQ_BYTE34;
         M_POSTINC: off_c = step_c;
         M_PREDEC: off_c = 16'h0000 - step_c;
         M_PCREL: begin
            base_c = {PROGRAM_COUNTER[15:1], 1'b0};
            off_c = {{8{REQ_BYTE2[7]}}, REQ_BYTE2};
            al_c = 1'b1;
         end
         default: off_c = 16'h0000;
      endcase
   end

   eag_addr_add u_add (
      .base(base_c),
      .offset(off_c),
      .align(al_c),
      .sum(sum_c),
      .sum_aligned(sum_al_c)
   );

   always_comb begin
      ea_c = 16'h0000;
      imm_c = 16'h0000;
      opv_c = 16'h0000;
      mem_c = 1'b0;
      immv_c = 1'b0;
      wb_c = 1'b0;
      br_c = 1'b0;
      rdreq_c = 1'b0;
      bv_c = byte_pick(REG_FILE, REQ_BITREG);
      bit_c = 3'h0;
      case (REQ_MODE)
         M_REG: begin
            opv_c = word_c ? reg_pick(REG_FILE, REQ_REG[2:0]) :
                    {8'h00, byte_pick(REG_FILE, REQ_REG)};
         end
         M_IND: begin
            ea_c = even_addr(rv_c, word_c || jump_c);
            mem_c = !jump_c;
            br_c = jump_c;
         end
         M_DISP: begin
            ea_c = sum_al_c;
            mem_c = 1'b1;
         end
         M_POSTINC: begin
            ea_c = even_addr(rv_c, word_c);
            mem_c = 1'b1;
            wb_c = 1'b1;
         end
         M_PREDEC: begin
            ea_c = sum_al_c;
            mem_c = 1'b1;
            wb_c = 1'b1;
         end
         M_ABS8: begin
            ea_c = {SHORT_ABS_PAGE, REQ_BYTE2};
            mem_c = 1'b1;
         end
         M_ABS16: begin
            ea_c = even_addr(REQ_BYTE34, word_c || jump_c);
            mem_c = !jump_c;
            br_c = jump_c;
         end
         M_IMM8: begin
            imm_c = {8'h00, REQ_BYTE2};
            immv_c = 1'b1;
         end
         M_IMM16: begin
            imm_c = REQ_BYTE34;
            immv_c = 1'b1;
         end
         M_PCREL: begin
            ea_c = sum_al_c;
            br_c = 1'b1;
         end
         M_MEMIND: rdreq_c = 1'b1;
         default: ea_c = 16'h0000;
      endcase
      if (REQ_CLASS == CL_SMALL_STEP) begin
         imm_c = REQ_STEP2 ? STEP_WORD : STEP_BYTE;
         immv_c = 1'b1;
      end
      if (REQ_CLASS == CL_BIT_IMM) begin
         bit_c = REQ_BIT_BYTE4 ? REQ_BYTE34[BITIDX_LSB +: 3] :
                 REQ_BYTE2[BITIDX_LSB +: 3];
      end else if (REQ_CLASS == CL_BIT_REGNUM) begin
         bit_c = bv_c[2:0];
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (acc && legal_c && rdreq_c) begin
                  st_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (MEM_RD_VALID) begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Pointer fetch from page zero; the answer may take any number of cycles
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         BUSY <= 1'b0;
         MEM_RD_REQ <= 1'b0;
         MEM_RD_ADDR <= ADDR_RESET;
      end else begin
         MEM_RD_REQ <= acc && legal_c && rdreq_c;
         if (acc && legal_c && rdreq_c) begin
            BUSY <= 1'b1;
            MEM_RD_ADDR <= {MEMIND_PAGE, REQ_BYTE2[7:1], 1'b0};
         end else if (st_q == ST_WAIT && MEM_RD_VALID) begin
            BUSY <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         EA_DONE <= 1'b0;
         EA_ILLEGAL <= 1'b0;
         EA_MEM <= 1'b0;
         IS_BRANCH <= 1'b0;
         EA_ADDR <= ADDR_RESET;
         ACC_WORD <= 1'b0;
         OPERAND_VALUE <= 16'h0000;
         IMM_VALID <= 1'b0;
         IMM_VALUE <= 16'h0000;
         BIT_INDEX <= 3'h0;
         WB_EN <= 1'b0;
         WB_REG <= 3'h0;
         WB_DATA <= 16'h0000;
      end else begin
         EA_DONE <= (acc && !(legal_c && rdreq_c)) ||
                    (st_q == ST_WAIT && MEM_RD_VALID);
         if (acc) begin
            // A refused request shows only the flag, nothing to act on
            EA_ILLEGAL <= !legal_c;
            EA_MEM <= legal_c && mem_c;
            IS_BRANCH <= legal_c && br_c;
            EA_ADDR <= ea_c;
            ACC_WORD <= word_c;
            OPERAND_VALUE <= opv_c;
            IMM_VALID <= legal_c && immv_c;
            IMM_VALUE <= imm_c;
            BIT_INDEX <= bit_c;
            WB_EN <= legal_c && wb_c;
            WB_REG <= sel_c;
            WB_DATA <= sum_c;
         end else if (st_q == ST_WAIT && MEM_RD_VALID) begin
            IS_BRANCH <= 1'b1;
            EA_ADDR <= {MEM_RD_DATA[15:1], 1'b0};
         end
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   a_dir_byte: assert property (
      acc && legal_c && REQ_MODE == M_REG && REQ_CLASS == CL_BYTE_ALU
      |=> !ACC_WORD && OPERAND_VALUE[15:8] == 8'h00)
      else $error("byte register operand not byte wide");
   a_ind_addr: assert property (
      acc && legal_c && REQ_MODE == M_IND && REQ_CLASS == CL_BYTE_MOVE
      |=> EA_DONE && EA_MEM && EA_ADDR == $past(rv_c))
      else $error("indirect address differs from register");
   a_disp_sum: assert property (
      acc && legal_c && REQ_MODE == M_DISP
      |=> EA_ADDR[15:1] == 15'(($past(rv_c) + $past(REQ_BYTE34)) >> 1))
      else $error("displacement address wrong");
   a_postinc_step: assert property (
      acc && legal_c && REQ_MODE == M_POSTINC && REQ_CLASS == CL_BYTE_MOVE
      |=> WB_EN && EA_ADDR == $past(rv_c) &&
          WB_DATA == 16'($past(rv_c) + 16'h0001))
      else $error("post-increment wrong");
   a_predec_word: assert property (
      acc && legal_c && REQ_MODE == M_PREDEC && word_c
      |=> WB_EN && WB_DATA == 16'($past(rv_c) - 16'h0002) &&
          EA_ADDR == {WB_DATA[15:1], 1'b0})
      else $error("pre-decrement wrong");
   a_short_abs: assert property (
      acc && legal_c && REQ_MODE == M_ABS8
      |=> EA_ADDR[15:8] == 8'hff)
      else $error("short absolute not in top page");
   a_abs16_refuse: assert property (
      acc && REQ_MODE == M_ABS16 &&
      (REQ_CLASS == CL_BYTE_ALU || REQ_CLASS == CL_BIT_IMM)
      |=> EA_DONE && EA_ILLEGAL && !EA_MEM)
      else $error("16-bit absolute accepted for wrong class");
   a_imm16_word: assert property (
      acc && REQ_MODE == M_IMM16 && REQ_CLASS != CL_WORD_MOVE
      |=> EA_ILLEGAL && !IMM_VALID)
      else $error("16-bit immediate outside word move");
   a_small_imm: assert property (
      acc && legal_c && REQ_CLASS == CL_SMALL_STEP
      |=> IMM_VALID && IMM_VALUE == ($past(REQ_STEP2) ? 16'h2 : 16'h1))
      else $error("small-step immediate wrong");
   a_branch_even: assert property (
      EA_DONE && IS_BRANCH |-> !EA_ADDR[0])
      else $error("odd branch target");
   a_memind_fetch: assert property (
      acc && legal_c && REQ_MODE == M_MEMIND
      |=> MEM_RD_REQ && BUSY && !EA_DONE && MEM_RD_ADDR[15:8] == 8'h00)
      else $error("memory indirect fetch not issued");
   a_sync_refuse: assert property (
      acc && REQ_CLASS == CL_SYNC |=> EA_DONE && EA_ILLEGAL)
      else $error("synchronised transfer not refused");
   a_stack_reg: assert property (
      acc && legal_c && (REQ_CLASS == CL_PUSH || REQ_CLASS == CL_POP)
      |=> WB_EN && WB_REG == 3'h7 && ACC_WORD)
      else $error("stack access not through register seven");

   c_memind: cover property (st_q == ST_WAIT && MEM_RD_VALID ##1 EA_DONE);
   c_push: cover property (acc && legal_c && REQ_CLASS == CL_PUSH);
   c_branch: cover property (acc && legal_c && REQ_MODE == M_PCREL);
   c_refused: cover property (acc && !legal_c);

endmodule

`default_nettype wire

// *** logic/eag_pkg.sv ***
package eag_pkg;

   // Instruction classes as they affect operand addressing
   typedef enum logic [3:0] {
      CL_BYTE_MOVE = 4'h0,
      CL_WORD_MOVE = 4'h1,
      CL_WORD_ALU = 4'h2,
      CL_SMALL_STEP = 4'h3,
      CL_MULDIV = 4'h4,
      CL_BYTE_ALU = 4'h5,
      CL_BIT_REGNUM = 4'h6,
      CL_BIT_IMM = 4'h7,
      CL_BRANCH = 4'h8,
      CL_JUMP = 4'h9,
      CL_PUSH = 4'ha,
      CL_POP = 4'hb,
      CL_SYNC = 4'hc,
      CL_OTHER = 4'hd
   } eag_class_e;

   typedef enum logic [3:0] {
      M_REG = 4'h0,
      M_IND = 4'h1,
      M_DISP = 4'h2,
      M_POSTINC = 4'h3,
      M_PREDEC = 4'h4,
      M_ABS8 = 4'h5,
      M_ABS16 = 4'h6,
      M_IMM8 = 4'h7,
      M_IMM16 = 4'h8,
      M_PCREL = 4'h9,
      M_MEMIND = 4'ha
   } eag_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01
   } eag_state_e;

   localparam logic [2:0] STACK_REG = 3'h7;
   localparam logic [7:0] SHORT_ABS_PAGE = 8'hff;
   localparam logic [7:0] MEMIND_PAGE = 8'h00;
   localparam int BITIDX_LSB = 4;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] ADDR_RESET = 16'h0000;

endpackage

// *** logic/eag_addr_add.sv ***
`timescale 1ns/100ps
`default_nettype none

// Sixteen-bit address adder; carries out of bit 15 are dropped on purpose
module eag_addr_add (
   input wire logic [15:0] base,
   input wire logic [15:0] offset,
   input wire logic align,
   output logic [15:0] sum,
   output logic [15:0] sum_aligned
);

   logic [16:0] full;

   always_comb begin
      full = {1'b0, base} + {1'b0, offset};
      sum = full[15:0];
      sum_aligned = align ? {full[15:1], 1'b0} : full[15:0];
   end

endmodule

`default_nettype wire

// *** sim/effective_address_generator_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module effective_address_generator_bench import eag_pkg::*;;
   logic CLOCK = 1'b0;
   logic RST_N = 1'b0;
   logic REQ_VALID = 1'b0;
   eag_class_e REQ_CLASS = CL_OTHER;
   eag_mode_e REQ_MODE = M_REG;
   logic REQ_STORE = 1'b0;
   logic REQ_STEP2 = 1'b0;
   logic REQ_BIT_BYTE4 = 1'b0;
   logic [3:0] REQ_REG = 4'h0;
   logic [3:0] REQ_BITREG = 4'h0;
   logic [7:0] REQ_BYTE2 = 8'h00;
   logic [15:0] REQ_BYTE34 = 16'h0000;
   logic [127:0] REG_FILE = '0;
   logic [15:0] PROGRAM_COUNTER = 16'h0000;
   logic [15:0] MEM_RD_DATA = 16'h0000;
   logic MEM_RD_VALID = 1'b0;
   logic BUSY, EA_DONE, EA_ILLEGAL, EA_MEM, IS_BRANCH, ACC_WORD;
   logic IMM_VALID, WB_EN, MEM_RD_REQ;
   logic [15:0] EA_ADDR, OPERAND_VALUE, IMM_VALUE, WB_DATA, MEM_RD_ADDR;
   logic [2:0] BIT_INDEX, WB_REG;
   int n_mismatch = 0;
   int n_compared = 0;

   eag_top i_dut (
      .CLOCK(CLOCK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
      .REQ_CLASS(REQ_CLASS), .REQ_MODE(REQ_MODE), .REQ_STORE(REQ_STORE),
      .REQ_STEP2(REQ_STEP2), .REQ_BIT_BYTE4(REQ_BIT_BYTE4),
      .REQ_REG(REQ_REG), .REQ_BITREG(REQ_BITREG), .REQ_BYTE2(REQ_BYTE2),
      .REQ_BYTE34(REQ_BYTE34), .REG_FILE(REG_FILE),
      .PROGRAM_COUNTER(PROGRAM_COUNTER), .MEM_RD_DATA(MEM_RD_DATA),
      .MEM_RD_VALID(MEM_RD_VALID), .BUSY(BUSY), .EA_DONE(EA_DONE),
      .EA_ILLEGAL(EA_ILLEGAL), .EA_MEM(EA_MEM), .IS_BRANCH(IS_BRANCH),
      .EA_ADDR(EA_ADDR), .ACC_WORD(ACC_WORD),
      .OPERAND_VALUE(OPERAND_VALUE), .IMM_VALID(IMM_VALID),
      .IMM_VALUE(IMM_VALUE), .BIT_INDEX(BIT_INDEX), .WB_EN(WB_EN),
      .WB_REG(WB_REG), .WB_DATA(WB_DATA), .MEM_RD_REQ(MEM_RD_REQ),
      .MEM_RD_ADDR(MEM_RD_ADDR)
   );

   always #10 CLOCK = ~CLOCK;

   task wrap_up;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task setr(input int n, input logic [15:0] v);
      @(posedge CLOCK);
      REG_FILE[16*n +: 16] <= v;
   endtask

   // Flags f are {store, step2, bit index from byte 4}
   task automatic rq(input eag_class_e c, input eag_mode_e m,
                     input logic [3:0] r, input logic [7:0] b2,
                     input logic [15:0] b34, input logic [2:0] f);
      @(posedge CLOCK);
      REQ_VALID <= 1'b1;
      REQ_CLASS <= c;
      REQ_MODE <= m;
      REQ_REG <= r;
      REQ_BYTE2 <= b2;
      REQ_BYTE34 <= b34;
      {REQ_STORE, REQ_STEP2, REQ_BIT_BYTE4} <= f;
      @(posedge CLOCK);
      REQ_VALID <= 1'b0;
   endtask

   // Bounded wait on EA_DONE (w = 0) or MEM_RD_REQ (w = 1)
   task automatic wt(input int w);
      for (int i = 0; i < 20; i++) begin
         #1;
         if (((w == 0) ? EA_DONE : MEM_RD_REQ) === 1'b1) begin
            return;
         end
         @(posedge CLOCK);
      end
      n_mismatch++;
      $display("[FAIL] %0t wait ran out %h %h", $time, w, 0);
      wrap_up();
   endtask

   // Refused requests must raise EA_ILLEGAL and leave EA_MEM, WB_EN, IMM_VALID and IS_BRANCH low
   task ill;
      chk(EA_ILLEGAL, 1'b1);
      chk({EA_MEM, WB_EN, IMM_VALID, IS_BRANCH}, 4'h0);
   endtask

   task t_regdir;
      setr(3, 16'h12ab);
      rq(CL_BYTE_MOVE, M_REG, 4'h3, 8'h00, 16'h0000, 3'b000);
      wt(0);
      chk(OPERAND_VALUE, 16'h0012);
      chk(ACC_WORD, 1'b0);
      rq(CL_BYTE_ALU, M_REG, 4'hb, 8'h00, 16'h0000, 3'b000);
      wt(0);
      chk(OPERAND_VALUE, 16'h00ab);
      rq(CL_WORD_ALU, M_REG, 4'h3, 8'h00, 16'h0000, 3'b000);
      wt(0);
      chk(OPERAND_VALUE, 16'h12ab);
      chk(ACC_WORD, 1'b1);
      rq(CL_MULDIV, M_REG, 4'h3, 8'h00, 16'h0000, 3'b000);
      wt(0);
      chk(ACC_WORD, 1'b1);
      $display("t_regdir done");
   endtask

   task t_indirect;
      setr(2, 16'hfffe);
      rq(CL_BYTE_MOVE, M_IND, 4'h2, 8'h00, 16'h0000, 3'b000);
      wt(0);
      chk({EA_ILLEGAL, EA_MEM}, 2'b01);
      chk(EA_ADDR, 16'hfffe);
      setr(2, 16'hfff0);
      rq(CL_WORD_MOVE, M_DISP, 4'h2, 8'h00, 16'h0013, 3'b000);
      wt(0);
      chk(EA_ADDR, 16'h0002);
      chk(ACC_WORD, 1'b1);
      rq(CL_BYTE_ALU, M_IND, 4'h2, 8'h00, 16'h0000, 3'b000);
      wt(0);
      ill();
      rq(CL_WORD_ALU, M_DISP, 4'h2, 8'h00, 16'h0013, 3'b000);
      wt(0);
      ill();
      $display("t_indirect done");
   endtask

   task t_steps;
      setr(1, 16'hffff);
      rq(CL_BYTE_MOVE, M_POSTINC, 4'h1, 8'h00, 16'h0000, 3'b000);
      wt(0);
      chk(EA_ADDR, 16'hffff);
      chk({WB_EN, WB_REG}, 4'h9);
      chk(WB_DATA, 16'h0000);
      setr(1, 16'h1000);
      rq(CL_WORD_MOVE, M_POSTINC, 4'h1, 8'h00, 16'h0000, 3'b000);
      wt(0);
      chk(EA_ADDR, 16'h1000);
      chk(WB_DATA, 16'h1002);
      setr(1, 16'h0000);
      rq(CL_BYTE_MOVE, M_PREDEC, 4'h1, 8'h00, 16'h0000, 3'b100);
      wt(0);
      chk(EA_ADDR, 16'hffff);
      chk(WB_DATA, 16'hffff);
      rq(CL_WORD_MOVE, M_PREDEC, 4'h1, 8'h00, 16'h0000, 3'b100);
      wt(0);
      chk(WB_DATA, 16'hfffe);
      rq(CL_BYTE_MOVE, M_POSTINC, 4'h1, 8'h00, 16'h0000, 3'b100);
      wt(0);
      ill();
      $display("t_steps done");
   endtask

   task t_abs_imm;
      rq(CL_BYTE_MOVE, M_ABS8, 4'h0, 8'h34, 16'h0000, 3'b000);
      wt(0);
      chk(EA_ADDR, 16'hff34);
      rq(CL_JUMP, M_ABS16, 4'h0, 8'h00, 16'h4567, 3'b000);
      wt(0);
      chk({EA_ILLEGAL, IS_BRANCH}, 2'b01);
      chk(EA_ADDR, 16'h4566);
      rq(CL_BYTE_ALU, M_ABS16, 4'h0, 8'h00, 16'h4567, 3'b000);
      wt(0);
      ill();
      rq(CL_BYTE_ALU, M_IMM8, 4'h0, 8'hb2, 16'h0000, 3'b000);
      wt(0);
      chk({EA_ILLEGAL, IMM_VALID}, 2'b01);
      chk(IMM_VALUE, 16'h00b2);
      rq(CL_WORD_MOVE, M_IMM16, 4'h0, 8'h00, 16'hbeef, 3'b000);
      wt(0);
      chk(IMM_VALUE, 16'hbeef);
      rq(CL_WORD_ALU, M_IMM16, 4'h0, 8'h00, 16'hbeef, 3'b000);
      wt(0);
      ill();
      for (int s = 0; s < 2; s++) begin
         rq(CL_SMALL_STEP, M_REG, 4'h0, 8'h00, 16'h0000, {1'b0, s[0], 1'b0});
         wt(0);
         chk(IMM_VALUE, 16'h0001 + 16'(s));
      end
      $display("t_abs_imm done");
   endtask

   task t_bits;
      rq(CL_BIT_IMM, M_REG, 4'h0, 8'h50, 16'h0000, 3'b000);
      wt(0);
      chk(BIT_INDEX, 3'h5);
      rq(CL_BIT_IMM, M_IND, 4'h0, 8'h00, 16'h0070, 3'b001);
      wt(0);
      chk(BIT_INDEX, 3'h7);
      setr(5, 16'h00fe);
      REQ_BITREG <= 4'hd;
      rq(CL_BIT_REGNUM, M_ABS8, 4'h0, 8'h10, 16'h0000, 3'b000);
      wt(0);
      chk(BIT_INDEX, 3'h6);
      chk(EA_ADDR, 16'hff10);
      rq(CL_BIT_IMM, M_POSTINC, 4'h0, 8'h50, 16'h0000, 3'b000);
      wt(0);
      ill();
      $display("t_bits done");
   endtask

   task t_branch;
      @(posedge CLOCK);
      PROGRAM_COUNTER <= 16'h0101;
      rq(CL_BRANCH, M_PCREL, 4'h0, 8'h80, 16'h0000, 3'b000);
      wt(0);
      chk(IS_BRANCH, 1'b1);
      chk(EA_ADDR, 16'h0080);
      @(posedge CLOCK);
      PROGRAM_COUNTER <= 16'hfff0;
      rq(CL_BRANCH, M_PCREL, 4'h0, 8'h7f, 16'h0000, 3'b000);
      wt(0);
      chk(EA_ADDR, 16'h006e);
      rq(CL_WORD_MOVE, M_PCREL, 4'h0, 8'h7f, 16'h0000, 3'b000);
      wt(0);
      ill();
      $display("t_branch done");
   endtask

   task t_memind;
      rq(CL_JUMP, M_MEMIND, 4'h0, 8'h23, 16'h0000, 3'b000);
      wt(1);
      chk(MEM_RD_ADDR, 16'h0022);
      chk(BUSY, 1'b1);
      @(posedge CLOCK);
      MEM_RD_VALID <= 1'b1;
      MEM_RD_DATA <= 16'h1235;
      // A request while busy must be dropped, not taken over the answer
      REQ_VALID <= 1'b1;
      REQ_CLASS <= CL_BYTE_MOVE;
      REQ_MODE <= M_ABS8;
      @(posedge CLOCK);
      MEM_RD_VALID <= 1'b0;
      REQ_VALID <= 1'b0;
      wt(0);
      chk({BUSY, IS_BRANCH, MEM_RD_REQ}, 3'b010);
      chk(EA_ADDR, 16'h1234);
      rq(CL_BYTE_MOVE, M_MEMIND, 4'h0, 8'h23, 16'h0000, 3'b000);
      wt(0);
      ill();
      $display("t_memind done");
   endtask

   task t_stack;
      setr(7, 16'h0100);
      rq(CL_PUSH, M_PREDEC, 4'h0, 8'h00, 16'h0000, 3'b100);
      wt(0);
      chk({WB_EN, WB_REG, ACC_WORD}, 5'h1f);
      chk(WB_DATA, 16'h00fe);
      chk(EA_ADDR, 16'h00fe);
      setr(7, 16'h0101);
      rq(CL_PUSH, M_PREDEC, 4'h0, 8'h00, 16'h0000, 3'b100);
      wt(0);
      chk(EA_ADDR, 16'h00fe);
      setr(7, 16'hfffe);
      rq(CL_POP, M_POSTINC, 4'h0, 8'h00, 16'h0000, 3'b000);
      wt(0);
      chk(EA_ADDR, 16'hfffe);
      chk(WB_DATA, 16'h0000);
      rq(CL_SYNC, M_IND, 4'h0, 8'h00, 16'h0000, 3'b000);
      wt(0);
      ill();
      $display("t_stack done");
   endtask

   initial begin
      repeat (8) @(posedge CLOCK);
      RST_N <= 1'b1;
      #1;
      chk({EA_DONE, BUSY, WB_EN}, 3'h0);
      chk(EA_ADDR, 16'h0000);
      t_regdir();
      t_indirect();
      t_steps();
      t_abs_imm();
      t_bits();
      t_branch();
      t_memind();
      t_stack();
      wrap_up();
   end
endmodule

`default_nettype wire
